/* ibch_defines.svh */
// constants of the i2c boot command handler
`ifndef IBCH_DEFINES_SVH
`define IBCH_DEFINES_SVH
`define IBCH_SLAVE_ADDR 7'h62
`define IBCH_CMD_NOP 8'h00
`define IBCH_CMD_WRMEM 8'h57
`define IBCH_CMD_RDMEM 8'h52
`define IBCH_CMD_CALCK 8'h4B
`define IBCH_CMD_GETCK 8'h43
`define IBCH_CMD_START 8'h47
`define IBCH_CMD_RDSCR 8'h44
`define IBCH_CMD_WRSCR 8'h45
`define IBCH_CMD_ROMSVC 8'h4A
`define IBCH_CMD_SETPTR 8'h4D
`define IBCH_FN_NOP 8'h00
`define IBCH_FN_VERSION 8'h01
`define IBCH_FN_RESET 8'h02
`define IBCH_SPACE_X 3'h0
`define IBCH_SPACE_Y 3'h2
`define IBCH_SPACE_P 3'h4
`define IBCH_ARGS_SETPTR 3'h5
`define IBCH_ARGS_START 3'h2
`define IBCH_ARGS_WRSCR 3'h2
`define IBCH_ARGS_ROMSVC 3'h1
`define IBCH_CLK_MHZ 250
`define IBCH_BOOT_TIMEOUT_US 1000
`define IBCH_ROM_BUSY_CYC 16
`endif

/* ibch_host_model.sv */
// i2c master host that loads the boot command handler
`timescale 1ns/1ps
`default_nettype none
module ibch_host_model (
  // pacing clock
  input wire logic core_clk,
  // bus levels after the pull-ups
  input wire logic scl,
  input wire logic sda,
  // low pulls the line, high releases it
  output logic scl_m,
  output logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // half of the 80 ns bus clock
  task automatic hp();
    repeat (10) @(posedge core_clk);
    #1;
  endtask
  // honours stretching, bounded so a stuck line cannot hang the run
  task automatic rise();
    int k;
    scl_m = 1'b1;
    k = 0;
    while (scl !== 1'b1 && k < 5000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    hp();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_m = b;
    hp();
    rise();
    s = sda;
    scl_m = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic start();
    sda_m = 1'b1;
    hp();
    rise();
    sda_m = 1'b0;
    hp();
    scl_m = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_m = 1'b0;
    hp();
    rise();
    sda_m = 1'b1;
    hp();
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

/* ibch_mem.sv */
// the three memory spaces as one word array with registered read
`timescale 1ns/1ps
`default_nettype none
module ibch_mem #(
  parameter int AW = 12
) (
  // clock
  input wire logic core_clk,
  // word port
  ibch_mem_if.mem bus
);
  logic [15:0] ram [2**AW];

  always_ff @(posedge core_clk) begin
    if (bus.we) begin
      ram[bus.addr] <= bus.wdata;
    end
    if (bus.re) begin
      bus.rdata <= ram[bus.addr];
    end
  end
endmodule
`default_nettype wire

/* ibch_mem_if.sv */
// word port between the command engine and the memory
`timescale 1ns/1ps
`default_nettype none
interface ibch_mem_if #(parameter int AW = 12);
  logic we;
  logic re;
  logic [AW-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctl(output we, re, addr, wdata, input rdata);
  modport mem(input we, re, addr, wdata, output rdata);
endinterface
`default_nettype wire

/* ibch_pkg.sv */
// types of the i2c boot command handler
package ibch_pkg;
  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_WR, SL_WR_ACK, SL_RD, SL_RD_ACK
  } ibch_sl_t;
  typedef enum logic [2:0] {
    CM_CMD, CM_ARG, CM_WDATA, CM_CKRD, CM_CKACC, CM_ROM, CM_APP
  } ibch_cm_t;
  typedef enum logic [1:0] {RS_NONE, RS_MEM, RS_CK, RS_SCR} ibch_rsrc_t;
  typedef enum logic [1:0] {K_DATA, K_FIRST, K_END} ibch_kind_t;
  typedef struct packed {
    ibch_kind_t kind;
    logic [7:0] data;
  } ibch_rx_t;
endpackage

/* ibch_top.sv */
// i2c boot command handler: i2c slave, receive buffer and command engine
`timescale 1ns/1ps
`default_nettype none
`include "ibch_defines.svh"
// What this block does
// RULE_01: command 0x57 writes received byte pairs, high first, from pointer for count.
// RULE_02: an odd trailing byte of a block write is dropped.
// RULE_03: every written word is added into the running checksum.
// RULE_04: end of a block write switches reads to the checksum.
// RULE_05: host sets the block pointer before memory or checksum commands.
// RULE_06: command 0x52 returns block words high byte first for count.
// RULE_07: command 0x4B computes a checksum over the pointed block.
// RULE_08: checksum is 16-bit sum of words plus start address plus space.
// RULE_09: end of checksum calculation switches reads to the checksum.
// RULE_10: command 0x43 returns the last checksum high byte first.
// RULE_11: in checksum state every read returns the same checksum again.
// RULE_12: command 0x47 with two address bytes starts the program there.
// RULE_13: once the program runs the command interpreter stops answering.
// RULE_14: command 0x44 returns the scratch word high byte first.
// RULE_15: command 0x45 loads two bytes into the scratch word.
// RULE_16: command 0x4A runs the selected ROM service routine to completion.
// RULE_17: no transfer is acknowledged while a service routine runs.
// RULE_18: host polls with no-op commands until acknowledged again.
// RULE_19: unknown service function bytes act as no-op.
// RULE_20: function 0x00 no-op, 0x01 version to scratch, 0x02 system reset.
// RULE_21: after power-up, reset after a timeout unless a host talks.
// RULE_22: service no-op re-initialises and idles waiting for commands.
// RULE_23: command 0x4D sets pointer and seeds checksum with address plus space.
// RULE_24: space byte 0x0, 0x2, 0x4 selects first data, second data, program.
// RULE_25: answer only to seven-bit slave address 0x62.
// RULE_26: command 0x00 is acknowledged and changes nothing.
// RULE_27: first byte of a write transfer is the command, arguments follow.
module ibch_top #(
  parameter int ADDR_W = 10,
  parameter int BUF_DEPTH = 2,
  parameter logic [15:0] ROM_VERSION = 16'h0001, // arbitrary value
  parameter int BOOT_TIMEOUT_CYC = `IBCH_BOOT_TIMEOUT_US * `IBCH_CLK_MHZ,
  parameter int ROM_BUSY_CYC = `IBCH_ROM_BUSY_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // i2c pins, open drain
  input wire logic scl,
  output logic scl_drv,
  output logic scl_oe,
  input wire logic sda,
  output logic sda_drv,
  output logic sda_oe,
  // program control
  output logic app_start,
  output logic [15:0] app_addr,
  output logic sys_reset_req,
  output logic rom_busy
);
  localparam int PW = $clog2(BUF_DEPTH);
  localparam int RW = $clog2(ROM_BUSY_CYC + 1);
  localparam int BW = $clog2(BOOT_TIMEOUT_CYC + 1);

  logic [2:0] scl_s_q, sda_s_q;
  logic scl_rise, scl_fall, start, stop, sda_now;
  ibch_pkg::ibch_sl_t sl_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, tx_byte;
  logic rw_q, wr_xfer_q, first_q, sda_oe_q, hold, tx_take, addr_hit;
  logic rx_pend_q, end_pend_q;
  ibch_pkg::ibch_rx_t rx_pend_data_q, in_data, out_data;
  ibch_pkg::ibch_rx_t buf_q [BUF_DEPTH];
  logic [PW:0] wp_q, rp_q;
  logic full, empty, push, pop, eng_ready;
  ibch_pkg::ibch_cm_t cm_q;
  logic [7:0] cmd_q, hi_q, rom_fn_q;
  logic [39:0] arg_q, arg_v;
  logic [2:0] argn_q, need, ptr_space_q;
  logic [15:0] ptr_addr_q, ptr_size_q, ck_q, cnt_q, scr_q, mem_idx;
  logic half_q, is_first, is_data, is_end, new_cmd, arg_done, cnt_left, wr_word;
  ibch_pkg::ibch_rsrc_t rsrc_q;
  logic rlo_q, rd_fetch_q, rd_lo_take, rom_done, app_run, boot_wait_q;
  logic [1:0] sp_idx;
  logic [RW-1:0] rom_cnt_q;
  logic [BW-1:0] boot_cnt_q;

  ibch_mem_if #(.AW(ADDR_W + 2)) mem_bus ();

  ibch_mem #(.AW(ADDR_W + 2)) u_mem (
    .core_clk(core_clk),
    .bus(mem_bus.mem)
  );

  // pins are asynchronous to core_clk; stage 0 feeds stage 1 only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl};
      sda_s_q <= {sda_s_q[1:0], sda};
    end
  end

  assign sda_now = sda_s_q[1];
  assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
  assign start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  assign stop = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

  assign app_run = (cm_q == ibch_pkg::CM_APP);
  assign rom_busy = (cm_q == ibch_pkg::CM_ROM);
  assign tx_take = ~start & ~stop & scl_fall &
    (((sl_q == ibch_pkg::SL_ADDR_ACK) & rw_q) | (sl_q == ibch_pkg::SL_RD_ACK));
  assign addr_hit = ~start & ~stop & scl_fall & (sl_q == ibch_pkg::SL_ADDR) & (bit_q == 4'h8) &
    (sh_q[7:1] == `IBCH_SLAVE_ADDR) & ~rom_busy & ~app_run; // [RULE_25] [RULE_17] [RULE_13]

  // stretch scl in the ack phase: a read waits until every written byte is
  // processed and a checksum run is over, a write waits for buffer room
  assign hold = ((sl_q == ibch_pkg::SL_ADDR_ACK) & rw_q &
    (~empty | rx_pend_q | end_pend_q | (cm_q == ibch_pkg::CM_CKRD) |
     (cm_q == ibch_pkg::CM_CKACC))) | ((sl_q == ibch_pkg::SL_WR_ACK) & rx_pend_q);
  assign scl_drv = 1'b0;
  assign scl_oe = hold;
  assign sda_drv = 1'b0;
  assign sda_oe = sda_oe_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sl_q <= ibch_pkg::SL_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start | stop) begin
      sl_q <= start ? ibch_pkg::SL_ADDR : ibch_pkg::SL_IDLE;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (sl_q)
        ibch_pkg::SL_IDLE: begin
        end
        ibch_pkg::SL_ADDR, ibch_pkg::SL_WR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_now};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            if (sl_q == ibch_pkg::SL_WR) begin
              sl_q <= ibch_pkg::SL_WR_ACK;
              sda_oe_q <= 1'b1;
            end else if (addr_hit) begin
              sl_q <= ibch_pkg::SL_ADDR_ACK;
              rw_q <= sh_q[0];
              sda_oe_q <= 1'b1;
            end else begin
              sl_q <= ibch_pkg::SL_IDLE;
            end
          end
        end
        ibch_pkg::SL_ADDR_ACK, ibch_pkg::SL_WR_ACK, ibch_pkg::SL_RD_ACK: begin
          if (sl_q == ibch_pkg::SL_RD_ACK && scl_rise && sda_now) begin
            sl_q <= ibch_pkg::SL_IDLE;
          end else if (scl_fall) begin
            bit_q <= 4'h0;
            if (tx_take) begin
              sl_q <= ibch_pkg::SL_RD;
              sh_q <= tx_byte;
              sda_oe_q <= ~tx_byte[7];
            end else begin
              sl_q <= ibch_pkg::SL_WR;
              sda_oe_q <= 1'b0;
            end
          end
        end
        ibch_pkg::SL_RD: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              sl_q <= ibch_pkg::SL_RD_ACK;
              sda_oe_q <= 1'b0;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= ~sh_q[6];
              bit_q <= bit_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // received bytes and end-of-write marks waiting for the buffer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_xfer_q <= 1'b0;
      first_q <= 1'b0;
      rx_pend_q <= 1'b0;
      rx_pend_data_q <= '0;
      end_pend_q <= 1'b0;
    end else begin
      if (start | stop) begin
        wr_xfer_q <= 1'b0;
      end else if (addr_hit && !sh_q[0]) begin
        wr_xfer_q <= 1'b1;
        first_q <= 1'b1; // [RULE_27]
      end
      if (!start && !stop && sl_q == ibch_pkg::SL_WR && scl_fall && bit_q == 4'h8) begin
        rx_pend_q <= 1'b1;
        rx_pend_data_q <= {first_q ? ibch_pkg::K_FIRST : ibch_pkg::K_DATA, sh_q};
        first_q <= 1'b0;
      end else if (push && rx_pend_q) begin
        rx_pend_q <= 1'b0;
      end
      if ((start | stop) && wr_xfer_q) begin
        end_pend_q <= 1'b1;
      end else if (push && !rx_pend_q) begin
        end_pend_q <= 1'b0;
      end
    end
  end

  // receive buffer; a full buffer stalls the master through scl stretching
  assign in_data = rx_pend_q ? rx_pend_data_q : {ibch_pkg::K_END, 8'h00};
  assign full = (wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]);
  assign empty = (wp_q == rp_q);
  assign push = (rx_pend_q | end_pend_q) & ~full;
  assign out_data = buf_q[rp_q[PW-1:0]];
  assign eng_ready = (cm_q == ibch_pkg::CM_CMD) | (cm_q == ibch_pkg::CM_ARG) |
    (cm_q == ibch_pkg::CM_WDATA) | app_run;
  assign pop = ~empty & eng_ready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_q[wp_q[PW-1:0]] <= in_data;
    end
  end

  // command decode
  assign is_first = pop && out_data.kind == ibch_pkg::K_FIRST;
  assign is_data = pop && out_data.kind == ibch_pkg::K_DATA;
  assign is_end = pop && out_data.kind == ibch_pkg::K_END;
  assign new_cmd = is_first && !app_run; // [RULE_13]
  assign arg_v = {arg_q[31:0], out_data.data};
  assign arg_done = (cm_q == ibch_pkg::CM_ARG) && is_data && (argn_q + 3'h1 == need);
  assign cnt_left = (cnt_q < ptr_size_q);
  assign wr_word = (cm_q == ibch_pkg::CM_WDATA) && is_data && half_q && cnt_left;
  assign rd_lo_take = tx_take && rsrc_q == ibch_pkg::RS_MEM && rlo_q && cnt_left;
  assign rom_done = rom_busy && rom_cnt_q == RW'(ROM_BUSY_CYC - 1);

  always_comb begin
    unique case (cmd_q)
      `IBCH_CMD_SETPTR: need = `IBCH_ARGS_SETPTR;
      `IBCH_CMD_START: need = `IBCH_ARGS_START;
      `IBCH_CMD_WRSCR: need = `IBCH_ARGS_WRSCR;
      default: need = `IBCH_ARGS_ROMSVC;
    endcase
  end

  always_comb begin
    unique case (ptr_space_q)
      `IBCH_SPACE_X: sp_idx = 2'h0; // [RULE_24]
      `IBCH_SPACE_Y: sp_idx = 2'h1;
      `IBCH_SPACE_P: sp_idx = 2'h2;
      default: sp_idx = 2'h3;
    endcase
  end

  // the pointer must have been set first; an unset pointer reads as zero
  assign mem_idx = ptr_addr_q + cnt_q; // [RULE_05]
  assign mem_bus.addr = {sp_idx, mem_idx[ADDR_W-1:0]};
  assign mem_bus.wdata = {hi_q, out_data.data}; // [RULE_01]
  assign mem_bus.we = wr_word;
  assign mem_bus.re = rd_fetch_q | ((cm_q == ibch_pkg::CM_CKRD) & cnt_left);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cm_q <= ibch_pkg::CM_CMD;
      cmd_q <= `IBCH_CMD_NOP;
      arg_q <= '0;
      argn_q <= 3'h0;
      half_q <= 1'b0;
      hi_q <= 8'h00;
    end else if (new_cmd) begin
      cmd_q <= out_data.data;
      argn_q <= 3'h0;
      half_q <= 1'b0;
      unique case (out_data.data)
        `IBCH_CMD_WRMEM: cm_q <= ibch_pkg::CM_WDATA; // [RULE_01]
        `IBCH_CMD_CALCK: cm_q <= ibch_pkg::CM_CKRD; // [RULE_07]
        `IBCH_CMD_SETPTR, `IBCH_CMD_START, `IBCH_CMD_WRSCR, `IBCH_CMD_ROMSVC:
          cm_q <= ibch_pkg::CM_ARG;
        default: cm_q <= ibch_pkg::CM_CMD; // [RULE_26]
      endcase
    end else begin
      unique case (cm_q)
        ibch_pkg::CM_CMD, ibch_pkg::CM_APP: begin
        end
        ibch_pkg::CM_ARG: begin
          if (is_data) begin
            arg_q <= arg_v;
            argn_q <= argn_q + 3'h1;
          end
          if (arg_done) begin
            if (cmd_q == `IBCH_CMD_START) begin
              cm_q <= ibch_pkg::CM_APP; // [RULE_13]
            end else if (cmd_q == `IBCH_CMD_ROMSVC) begin
              cm_q <= ibch_pkg::CM_ROM; // [RULE_16]
            end else begin
              cm_q <= ibch_pkg::CM_CMD;
            end
          end else if (is_end) begin
            cm_q <= ibch_pkg::CM_CMD;
          end
        end
        ibch_pkg::CM_WDATA: begin
          if (is_data) begin
            half_q <= ~half_q;
            hi_q <= out_data.data;
          end else if (is_end) begin
            cm_q <= ibch_pkg::CM_CMD; // [RULE_02]
          end
        end
        ibch_pkg::CM_CKRD: cm_q <= cnt_left ? ibch_pkg::CM_CKACC : ibch_pkg::CM_CMD;
        ibch_pkg::CM_CKACC: cm_q <= ibch_pkg::CM_CKRD;
        ibch_pkg::CM_ROM: begin
          if (rom_done) begin
            cm_q <= ibch_pkg::CM_CMD;
          end
        end
      endcase
    end
  end

  // block pointer, word count and checksum
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr_addr_q <= 16'h0000;
      ptr_size_q <= 16'h0000;
      ptr_space_q <= `IBCH_SPACE_X;
      ck_q <= 16'h0000;
      cnt_q <= 16'h0000;
    end else if (arg_done && cmd_q == `IBCH_CMD_SETPTR) begin
      ptr_addr_q <= arg_v[39:24]; // [RULE_23]
      ptr_size_q <= arg_v[23:8];
      ptr_space_q <= arg_v[2:0];
      ck_q <= arg_v[39:24] + {13'h0000, arg_v[2:0]}; // [RULE_23]
    end else if (new_cmd && (out_data.data == `IBCH_CMD_WRMEM ||
                             out_data.data == `IBCH_CMD_RDMEM)) begin
      cnt_q <= 16'h0000;
    end else if (new_cmd && out_data.data == `IBCH_CMD_CALCK) begin
      cnt_q <= 16'h0000;
      ck_q <= ptr_addr_q + {13'h0000, ptr_space_q}; // [RULE_08]
    end else if (wr_word) begin
      ck_q <= ck_q + mem_bus.wdata; // [RULE_03]
      cnt_q <= cnt_q + 16'h0001;
    end else if (cm_q == ibch_pkg::CM_CKACC) begin
      ck_q <= ck_q + mem_bus.rdata; // [RULE_08]
      cnt_q <= cnt_q + 16'h0001;
    end else if (rd_lo_take) begin
      cnt_q <= cnt_q + 16'h0001; // [RULE_06]
    end
  end

  // what a read transfer returns
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsrc_q <= ibch_pkg::RS_NONE;
      rlo_q <= 1'b0;
      rd_fetch_q <= 1'b0;
    end else begin
      rd_fetch_q <= rd_lo_take;
      if (new_cmd && out_data.data != `IBCH_CMD_NOP) begin
        rlo_q <= 1'b0;
        unique case (out_data.data)
          `IBCH_CMD_RDMEM: begin
            rsrc_q <= ibch_pkg::RS_MEM; // [RULE_06]
            rd_fetch_q <= 1'b1;
          end
          `IBCH_CMD_GETCK: rsrc_q <= ibch_pkg::RS_CK; // [RULE_10]
          `IBCH_CMD_RDSCR: rsrc_q <= ibch_pkg::RS_SCR; // [RULE_14]
          default: rsrc_q <= ibch_pkg::RS_NONE;
        endcase
      end else if ((cm_q == ibch_pkg::CM_WDATA && is_end) ||
                   (cm_q == ibch_pkg::CM_CKRD && !cnt_left)) begin
        rsrc_q <= ibch_pkg::RS_CK; // [RULE_04] [RULE_09]
        rlo_q <= 1'b0;
      end else if (tx_take) begin
        rlo_q <= ~rlo_q; // [RULE_11]
      end
    end
  end

  always_comb begin
    unique case (rsrc_q)
      ibch_pkg::RS_MEM: tx_byte = !cnt_left ? 8'h00 :
        (rlo_q ? mem_bus.rdata[7:0] : mem_bus.rdata[15:8]);
      ibch_pkg::RS_CK: tx_byte = rlo_q ? ck_q[7:0] : ck_q[15:8]; // [RULE_10] [RULE_11]
      ibch_pkg::RS_SCR: tx_byte = rlo_q ? scr_q[7:0] : scr_q[15:8]; // [RULE_14]
      default: tx_byte = 8'h00;
    endcase
  end

  // scratch exchange word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scr_q <= 16'h0000;
    end else if (arg_done && cmd_q == `IBCH_CMD_WRSCR) begin
      scr_q <= arg_v[15:0]; // [RULE_15]
    end else if (rom_done && rom_fn_q == `IBCH_FN_VERSION) begin
      scr_q <= ROM_VERSION; // [RULE_20]
    end
  end

  // service routines, boot wait timeout and program start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rom_fn_q <= `IBCH_FN_NOP;
      rom_cnt_q <= '0;
      boot_wait_q <= 1'b1;
      boot_cnt_q <= '0;
      sys_reset_req <= 1'b0;
      app_start <= 1'b0;
      app_addr <= 16'h0000;
    end else begin
      app_start <= 1'b0;
      if (arg_done && cmd_q == `IBCH_CMD_START) begin
        app_start <= 1'b1; // [RULE_12]
        app_addr <= arg_v[15:0];
      end
      if (arg_done && cmd_q == `IBCH_CMD_ROMSVC) begin
        rom_fn_q <= arg_v[7:0]; // [RULE_19]
        rom_cnt_q <= '0;
      end else if (rom_busy) begin
        rom_cnt_q <= rom_cnt_q + 1'b1; // [RULE_17]
      end
      // the service routine re-initialises: the power-up timeout ends here
      if (addr_hit || (arg_done && cmd_q == `IBCH_CMD_ROMSVC)) begin
        boot_wait_q <= 1'b0; // [RULE_21] [RULE_22]
      end
      if (boot_wait_q) begin
        boot_cnt_q <= (boot_cnt_q == BW'(BOOT_TIMEOUT_CYC - 1)) ? '0 :
          boot_cnt_q + 1'b1;
      end
      sys_reset_req <= (rom_done && rom_fn_q == `IBCH_FN_RESET) ||
        (boot_wait_q && boot_cnt_q == BW'(BOOT_TIMEOUT_CYC - 1)); // [RULE_20] [RULE_21]
    end
  end
endmodule
`default_nettype wire

/* ibch_top_assertions.sv */
// port-level checks of the i2c boot command handler
`timescale 1ns/1ps
`default_nettype none
module ibch_top_assertions #(
  parameter int ROM_BUSY_CYC = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // i2c pins
  input wire logic scl,
  input wire logic scl_drv,
  input wire logic scl_oe,
  input wire logic sda,
  input wire logic sda_drv,
  input wire logic sda_oe,
  // program control
  input wire logic app_start,
  input wire logic [15:0] app_addr,
  input wire logic sys_reset_req,
  input wire logic rom_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic app_seen_q;
  logic [5:0] app_age_q;
  int busy_cnt_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) app_seen_q <= 1'b0;
    else if (app_start) app_seen_q <= 1'b1;
  end
  // saturates so the quiet check holds for the rest of the run
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) app_age_q <= 6'h00;
    else if (app_seen_q && app_age_q != 6'h3F) app_age_q <= app_age_q + 6'h01;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) busy_cnt_q <= 0;
    else if (rom_busy) busy_cnt_q <= busy_cnt_q + 1;
    else busy_cnt_q <= 0;
  end
  sequence one_pulse(sig);
    sig ##1 !sig;
  endsequence
  chk_app_pulse: assert property (app_start |-> one_pulse(app_start))
    else $error("app start wider than one cycle");
  chk_app_once: assert property (app_seen_q |-> !app_start)
    else $error("second app start");
  chk_app_hold: assert property (app_seen_q |-> $stable(app_addr))
    else $error("app address moved");
  chk_app_mute: assert property (app_age_q > 6'h28 |-> !sda_oe)
    else $error("bus driven after app start");
  chk_reset_pulse: assert property (sys_reset_req |-> one_pulse(sys_reset_req))
    else $error("reset request wider than one cycle");
  chk_busy_max: assert property (rom_busy |-> busy_cnt_q < ROM_BUSY_CYC)
    else $error("service routine too long");
  chk_busy_len: assert property ($fell(rom_busy) |-> busy_cnt_q == ROM_BUSY_CYC)
    else $error("service routine length wrong");
  chk_busy_noack: assert property (rom_busy && $past(rom_busy, 8) |-> !$rose(sda_oe))
    else $error("ack while service routine runs");
  chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("data changed while clock high");
  chk_drv_zero: assert property (!scl_drv && !sda_drv)
    else $error("open drain pin driven high");
endmodule
`default_nettype wire

/* ibch_top_tb.sv */
// self-checking bench of the i2c boot command handler
`timescale 1ns/1ps
`default_nettype none
module ibch_top_tb;
  typedef logic [7:0] ibch_bq_t[$];
  localparam int BUSY = 400;
  localparam int BOOT = 200;
  localparam logic [15:0] VER = 16'h5A3C; // arbitrary value
  logic core_clk, rst, scl_m, sda_m, scl_drv, scl_oe, sda_drv, sda_oe;
  logic app_start, sys_reset_req, rom_busy;
  logic [15:0] app_addr;
  wire logic scl, sda;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_sys = 0;
  int n_app = 0;
  int base_sys = 0;
  assign scl = scl_oe ? scl_drv : scl_m;
  assign sda = sda_oe ? sda_drv : sda_m;
  ibch_top #(.ROM_VERSION(VER), .BOOT_TIMEOUT_CYC(BOOT), .ROM_BUSY_CYC(BUSY)) dut (
    .core_clk(core_clk), .rst(rst), .scl(scl), .scl_drv(scl_drv), .scl_oe(scl_oe),
    .sda(sda), .sda_drv(sda_drv), .sda_oe(sda_oe), .app_start(app_start),
    .app_addr(app_addr), .sys_reset_req(sys_reset_req), .rom_busy(rom_busy));
  ibch_host_model host (.core_clk(core_clk), .scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (sys_reset_req === 1'b1) n_sys++;
    if (app_start === 1'b1) n_app++;
  end
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic do_rst();
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
  endtask
  task automatic wr(input logic [6:0] sa, input ibch_bq_t q, output logic ack);
    logic a;
    host.start();
    host.wr_byte({sa, 1'b0}, ack);
    foreach (q[i]) begin
      host.wr_byte(q[i], a);
      ack &= a;
    end
    host.stop();
  endtask
  task automatic cmd(input ibch_bq_t q);
    logic a;
    wr(7'h62, q, a);
    chk("cmd ack", 16'h0001, {15'h0000, a});
  endtask
  task automatic rd_chk(input string what, input ibch_bq_t e);
    logic a;
    logic [7:0] d;
    host.start();
    host.wr_byte({7'h62, 1'b1}, a);
    foreach (e[i]) begin
      host.rd_byte(i == e.size() - 1, d);
      chk(what, {8'h00, e[i]}, {8'h00, d});
    end
    host.stop();
  endtask
  function automatic logic [15:0] wd(input int s, input int k);
    return {4'(s), 4'(k), 8'hC3};
  endfunction
  task automatic t_boot();
    repeat (BOOT - 10) @(negedge core_clk);
    chk("boot early", 16'h0000, 16'(n_sys));
    repeat (20) @(negedge core_clk);
    chk("boot reset", 16'h0001, 16'(n_sys));
  endtask
  task automatic t_addr();
    logic a;
    wr(7'h63, '{8'h00}, a);
    chk("foreign addr", 16'h0000, {15'h0000, a});
    cmd('{8'h00});
    base_sys = n_sys;
  endtask
  task automatic t_scratch();
    cmd('{8'h45, 8'hA5, 8'h5A});
    cmd('{8'h44});
    rd_chk("scratch", '{8'hA5, 8'h5A, 8'hA5, 8'h5A});
  endtask
  task automatic t_mem();
    logic [15:0] c, w0, w1;
    for (int s = 0; s < 6; s += 2) begin
      w0 = wd(s, 0);
      w1 = wd(s, 1);
      c = 16'h0020 + 16'(s) + w0 + w1;
      cmd('{8'h4D, 8'h00, 8'h20, 8'h00, 8'h03, 8'(s)});
      cmd('{8'h57, w0[15:8], w0[7:0], w1[15:8], w1[7:0], 8'hEE});
      rd_chk("wr sum", '{c[15:8], c[7:0], c[15:8], c[7:0]});
    end
    for (int s = 0; s < 6; s += 2) begin
      w0 = wd(s, 0);
      w1 = wd(s, 1);
      c = 16'h0020 + 16'(s) + w0 + w1;
      cmd('{8'h4D, 8'h00, 8'h20, 8'h00, 8'h02, 8'(s)});
      cmd('{8'h52});
      rd_chk("mem", '{w0[15:8], w0[7:0], w1[15:8], w1[7:0], 8'h00});
      cmd('{8'h4B});
      rd_chk("calc", '{c[15:8], c[7:0], c[15:8], c[7:0]});
      cmd('{8'h00});
      rd_chk("nop keeps", '{c[15:8], c[7:0]});
      cmd('{8'h43});
      rd_chk("get sum", '{c[15:8], c[7:0]});
    end
  endtask
  task automatic t_rom();
    logic a;
    int base, polls;
    logic [7:0] fn[4] = '{8'h01, 8'h07, 8'h00, 8'h02};
    chk("timeout off", 16'(base_sys), 16'(n_sys));
    foreach (fn[i]) begin
      base = n_sys;
      cmd('{8'h4A, fn[i]});
      polls = 0;
      a = 1'b0;
      while (a !== 1'b1 && polls < 8) begin
        wr(7'h62, '{8'h00}, a);
        polls++;
      end
      chk("busy poll", 16'h0001, {15'h0000, polls > 1 && a === 1'b1});
      chk("sys reset", {15'h0000, fn[i] == 8'h02}, 16'(n_sys - base));
      if (fn[i] != 8'h02) begin
        cmd('{8'h44});
        rd_chk("version", '{VER[15:8], VER[7:0]});
      end
    end
    do_rst();
  endtask
  task automatic t_app();
    logic a;
    cmd('{8'h47, 8'h01, 8'h00});
    chk("app start", 16'h0001, 16'(n_app));
    chk("app addr", 16'h0100, app_addr);
    wr(7'h62, '{8'h00}, a);
    chk("after app", 16'h0000, {15'h0000, a});
  endtask
  initial begin
    do_rst();
    t_boot();
    t_addr();
    t_scratch();
    t_mem();
    t_rom();
    t_app();
    end_sim();
  end
  // about twice the expected length of the run
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    end_sim();
  end
endmodule
bind ibch_top ibch_top_assertions #(.ROM_BUSY_CYC(ROM_BUSY_CYC)) u_chk (
  .core_clk(core_clk), .rst(rst), .scl(scl), .scl_drv(scl_drv), .scl_oe(scl_oe), .sda(sda),
  .sda_drv(sda_drv), .sda_oe(sda_oe), .app_start(app_start), .app_addr(app_addr),
  .sys_reset_req(sys_reset_req), .rom_busy(rom_busy));
`default_nettype wire
